// file: core/ssd_defs.vh
`ifndef SSD_DEFS_VH
`define SSD_DEFS_VH
`define SSD_A_CMD 8'h00
`define SSD_A_CTRL 8'h04
`define SSD_A_STCNT 8'h08
`define SSD_A_SCALE 8'h0c
`define SSD_A_OFFS 8'h10
`define SSD_A_LIMLO 8'h14
`define SSD_A_LIMHI 8'h18
`define SSD_A_OCOND 8'h1c
`define SSD_A_ORISE 8'h20
`define SSD_A_OFALL 8'h24
`define SSD_A_OEVT 8'h28
`define SSD_A_OEN 8'h2c
`define SSD_A_SEVT 8'h30
`define SSD_A_SEN 8'h34
`define SSD_A_SRE 8'h38
`define SSD_A_STB 8'h3c
`define SSD_A_OBUF 8'h40
`define SSD_A_DVAL 8'h44
`define SSD_A_ISTAT 8'h48
`define SSD_A_IEN 8'h4c
`define SSD_A_ICLR 8'h50
`define SSD_CMD_INIT 4'h1
`define SSD_CMD_WAIT 4'h2
`define SSD_CMD_OPCQ 4'h3
`define SSD_CMD_OPC 4'h4
`define SSD_CMD_CLS 4'h5
`define SSD_CMD_RST 4'h6
`define SSD_CMD_RECALC 4'h7
`define SSD_CTL_MATH 0
`define SSD_CTL_LIMIT 1
`define SSD_CTL_STATS 2
`define SSD_CTL_DISP 3
`define SSD_CTL_FEED 4
`define SSD_CTL_GRAPH 5
`define SSD_CTL_AUTO 6
`define SSD_CTRL_RST 7'h08
`define SSD_OPER_MEAS 4
`define SSD_STB_ESB 5
`define SSD_STB_RQS 6
`define SSD_STB_OPER 7
`define SSD_ESR_OPC 0
`define SSD_SCALE_RST 16'h0001
`define SSD_OFFS_RST 32'h00000000
`define SSD_STCNT_RST 16'h0064
`define SSD_LIMLO_RST 32'h00000000
`define SSD_LIMHI_RST 32'hffffffff
`define SSD_MODE_RAW 3'h0
`define SSD_MODE_SCALED 3'h1
`define SSD_MODE_GRAPH 3'h2
`define SSD_MODE_STATS 3'h3
`endif

// file: core/ssd_divider.v
`timescale 1ns/1ps
`default_nettype none
module ssd_divider #(
   parameter NW = 48,
   parameter DW = 16
) (
   input wire clk_i,
   input wire rst_n_i,
   input wire start_i,
   input wire [NW-1:0] num_i,
   input wire [DW-1:0] den_i,
   output reg busy_o,
   output reg done_o,
   output reg [NW-1:0] quo_o
);
   localparam integer NCNT = NW;
   reg [DW-1:0] rem_reg;
   reg [DW-1:0] den_reg;
   reg [7:0] cnt_reg;
   wire [DW:0] shifted = {rem_reg, quo_o[NW-1]};
   wire [DW:0] diff = shifted - {1'b0, den_reg};
   wire fits = (shifted >= {1'b0, den_reg});
   // restoring divide, one quotient bit per cycle to keep it small
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rem_reg <= {DW{1'b0}};
         den_reg <= {DW{1'b0}};
         cnt_reg <= 8'h00;
         busy_o <= 1'b0;
         done_o <= 1'b0;
         quo_o <= {NW{1'b0}};
      end else begin
         done_o <= 1'b0;
         if (start_i) begin
            rem_reg <= {DW{1'b0}};
            den_reg <= den_i;
            quo_o <= num_i;
            cnt_reg <= NCNT[7:0];
            busy_o <= 1'b1;
         end else if (busy_o) begin
            rem_reg <= fits ? diff[DW-1:0] : shifted[DW-1:0];
            quo_o <= {quo_o[NW-2:0], fits};
            cnt_reg <= cnt_reg - 8'h01;
            if (cnt_reg == 8'h01) begin
               busy_o <= 1'b0;
               done_o <= 1'b1;
            end
         end
      end
   end
endmodule // ssd_divider
`default_nettype wire

// file: core/ssd_top.v
`timescale 1ns/1ps
`default_nettype none
`include "ssd_defs.vh"
module ssd_top #(
   parameter DW = 32,
   parameter SW = 16,
   parameter SUMW = 48
) (
   // clock and reset
   input wire CLK_I,
   input wire RST_N_I,
   // apb slave
   input wire PSEL_I,
   input wire PENABLE_I,
   input wire PWRITE_I,
   input wire [7:0] PADDR_I,
   input wire [31:0] PWDATA_I,
   output reg [31:0] PRDATA_O,
   output reg PREADY_O,
   output reg PSLVERR_O,
   // measurement front end, same clock
   input wire MEAS_VALID_I,
   input wire [DW-1:0] MEAS_DATA_I,
   output reg MEAS_START_O,
   // display
   output reg [DW-1:0] DISP_VALUE_O,
   output reg [2:0] DISP_MODE_O,
   output reg [1:0] DISP_LIMIT_O,
   output reg DISP_BLANK_O,
   output reg REMOTE_LED_O,
   output reg SRQ_LED_O,
   // service request and interrupt
   output reg SRQ_O,
   output reg IRQ_O
);
   reg [6:0] ctrl_reg;
   reg [SW-1:0] stcnt_reg;
   reg [SW-1:0] scale_reg;
   reg [DW-1:0] offs_reg;
   reg [DW-1:0] limlo_reg;
   reg [DW-1:0] limhi_reg;
   reg [15:0] orise_reg;
   reg [15:0] ofall_reg;
   reg [15:0] oevt_reg;
   reg [15:0] oen_reg;
   reg [15:0] oprev_reg;
   reg [7:0] sevt_reg;
   reg [7:0] sen_reg;
   reg [7:0] sre_reg;
   reg [3:0] istat_reg;
   reg [3:0] ien_reg;
   reg run_reg;
   reg mwait_reg;
   reg [SW-1:0] remain_reg;
   reg [SW-1:0] n_reg;
   reg [SUMW-1:0] sum_reg;
   reg div_go_reg;
   reg [DW-1:0] raw_reg;
   reg [DW-1:0] mean_reg;
   reg [DW-1:0] dval_reg;
   reg [1:0] dlim_reg;
   reg wai_reg;
   reg slot_vld_reg;
   reg [3:0] slot_op_reg;
   reg opc_arm_reg;
   reg opcq_arm_reg;
   reg obuf_vld_reg;
   reg [31:0] rdata_next;
   reg dec_ok;
   wire div_busy;
   wire div_done;
   wire [SUMW-1:0] div_quo;
   // bus handshake: answer one cycle into the access phase; OBUF reads stall on a pending query, CMD writes on a held command
   wire acc = PSEL_I & PENABLE_I;
   wire fin = acc & PREADY_O;
   wire wr_fin = fin & PWRITE_I;
   wire rd_fin = fin & ~PWRITE_I;
   wire busy = run_reg | div_busy | div_go_reg;
   wire cmd_wr = wr_fin & (PADDR_I == `SSD_A_CMD);
   wire obuf_stall = ~PWRITE_I & (PADDR_I == `SSD_A_OBUF) & opcq_arm_reg;
   wire cmd_stall = PWRITE_I & (PADDR_I == `SSD_A_CMD) & slot_vld_reg;
   wire answer = acc & ~PREADY_O & ~obuf_stall & ~cmd_stall;
   wire slot_go = slot_vld_reg & ~wai_reg;
   wire direct = cmd_wr & ~wai_reg & ~slot_vld_reg;
   wire ex = slot_go | direct;
   wire [3:0] ex_op = slot_go ? slot_op_reg : PWDATA_I[3:0];
   wire ex_init = ex & (ex_op == `SSD_CMD_INIT);
   wire ex_cls = ex & (ex_op == `SSD_CMD_CLS);
   wire ex_rst = ex & (ex_op == `SSD_CMD_RST);
   wire ex_recalc = ex & (ex_op == `SSD_CMD_RECALC);

   wire take = MEAS_VALID_I & mwait_reg;
   wire last = take & (remain_reg == {{(SW-1){1'b0}}, 1'b1});
   wire m_en = ctrl_reg[`SSD_CTL_MATH];
   wire l_en = ctrl_reg[`SSD_CTL_LIMIT];
   wire s_en = ctrl_reg[`SSD_CTL_STATS];
   wire d_en = ctrl_reg[`SSD_CTL_DISP];
   wire stats_sel = s_en & ctrl_reg[`SSD_CTL_FEED];
   wire graph = l_en & ctrl_reg[`SSD_CTL_GRAPH] & ~stats_sel;

   wire [DW-1:0] src = take ? MEAS_DATA_I : raw_reg;
   wire [DW+SW-1:0] prod = src * scale_reg;
   wire [DW-1:0] mval = m_en ? (prod[DW-1:0] + offs_reg) : src;
   wire below = l_en & (mval < limlo_reg);
   wire above = l_en & (mval > limhi_reg);
   wire refresh = take | ex_recalc;
   wire [15:0] ocond = {11'h000, run_reg, 4'h0};
   wire [15:0] oset = (orise_reg & ocond & ~oprev_reg) |
                      (ofall_reg & ~ocond & oprev_reg);
   wire opc_set = opc_arm_reg & ~busy;
   wire [7:0] sset = {7'h00, opc_set};
   wire oevt_rd = rd_fin & (PADDR_I == `SSD_A_OEVT);
   wire sevt_rd = rd_fin & (PADDR_I == `SSD_A_SEVT);
   wire oper_sum = |(oevt_reg & oen_reg);
   wire esb_sum = |(sevt_reg & sen_reg);
   wire [7:0] stb_low = {oper_sum, 1'b0, esb_sum, 5'h00};
   wire rqs = |(stb_low & sre_reg & 8'hbf);
   wire [7:0] stb = {oper_sum, rqs, esb_sum, 5'h00};
   wire meas_end = oprev_reg[`SSD_OPER_MEAS] & ~run_reg;
   wire [3:0] iset = {take & (below | above), rqs & ~SRQ_O, opc_set, meas_end};
   wire iclr_wr = wr_fin & (PADDR_I == `SSD_A_ICLR);

   always @* begin
      rdata_next = 32'h00000000;
      dec_ok = 1'b1;
      case (PADDR_I)
         `SSD_A_CMD: rdata_next = 32'h00000000;
         `SSD_A_CTRL: rdata_next = {25'h0000000, ctrl_reg};
         `SSD_A_STCNT: rdata_next = {16'h0000, stcnt_reg};
         `SSD_A_SCALE: rdata_next = {16'h0000, scale_reg};
         `SSD_A_OFFS: rdata_next = offs_reg;
         `SSD_A_LIMLO: rdata_next = limlo_reg;
         `SSD_A_LIMHI: rdata_next = limhi_reg;
         `SSD_A_OCOND: rdata_next = {16'h0000, ocond};
         `SSD_A_ORISE: rdata_next = {16'h0000, orise_reg};
         `SSD_A_OFALL: rdata_next = {16'h0000, ofall_reg};
         `SSD_A_OEVT: rdata_next = {16'h0000, oevt_reg};
         `SSD_A_OEN: rdata_next = {16'h0000, oen_reg};
         `SSD_A_SEVT: rdata_next = {24'h000000, sevt_reg};
         `SSD_A_SEN: rdata_next = {24'h000000, sen_reg};
         `SSD_A_SRE: rdata_next = {24'h000000, sre_reg};
         `SSD_A_STB: rdata_next = {24'h000000, stb};
         `SSD_A_OBUF: rdata_next = {31'h00000000, obuf_vld_reg};
         `SSD_A_DVAL: rdata_next = dval_reg;
         `SSD_A_ISTAT: rdata_next = {28'h0000000, istat_reg};
         `SSD_A_IEN: rdata_next = {28'h0000000, ien_reg};
         `SSD_A_ICLR: rdata_next = 32'h00000000;
         default: dec_ok = 1'b0;
      endcase
   end

   ssd_divider #(.NW(SUMW), .DW(SW)) u_div (
      .clk_i(CLK_I),
      .rst_n_i(RST_N_I),
      .start_i(div_go_reg),
      .num_i(sum_reg),
      .den_i(n_reg),
      .busy_o(div_busy),
      .done_o(div_done),
      .quo_o(div_quo)
   );

   // bus response and status flags
   always @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         PREADY_O <= 1'b0;
         PRDATA_O <= 32'h00000000;
         PSLVERR_O <= 1'b0;
         REMOTE_LED_O <= 1'b0;
         oprev_reg <= 16'h0000;
         oevt_reg <= 16'h0000;
         sevt_reg <= 8'h00;
         istat_reg <= 4'h0;
         SRQ_O <= 1'b0;
         SRQ_LED_O <= 1'b0;
         IRQ_O <= 1'b0;
      end else begin
         PREADY_O <= answer;
         PRDATA_O <= answer & ~PWRITE_I & dec_ok ? rdata_next : 32'h00000000;
         PSLVERR_O <= answer & ~dec_ok;
         if (fin) begin
            REMOTE_LED_O <= 1'b1;
         end
         oprev_reg <= ocond;
         oevt_reg <= ((oevt_rd | ex_cls) ? 16'h0000 : oevt_reg) | oset;
         sevt_reg <= ((sevt_rd | ex_cls) ? 8'h00 : sevt_reg) | sset;
         istat_reg <= (iclr_wr ? (istat_reg & ~PWDATA_I[3:0]) : istat_reg) | iset;
         SRQ_O <= rqs;
         SRQ_LED_O <= rqs;
         IRQ_O <= |(istat_reg & ien_reg);
      end
   end

   // software settings
   always @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         ctrl_reg <= `SSD_CTRL_RST;
         stcnt_reg <= `SSD_STCNT_RST;
         scale_reg <= `SSD_SCALE_RST;
         offs_reg <= `SSD_OFFS_RST;
         limlo_reg <= `SSD_LIMLO_RST;
         limhi_reg <= `SSD_LIMHI_RST;
         orise_reg <= 16'h0000;
         ofall_reg <= 16'h0000;
         oen_reg <= 16'h0000;
         sen_reg <= 8'h00;
         sre_reg <= 8'h00;
         ien_reg <= 4'h0;
      end else if (ex_rst) begin
         ctrl_reg <= `SSD_CTRL_RST;
         stcnt_reg <= `SSD_STCNT_RST;
         scale_reg <= `SSD_SCALE_RST;
         offs_reg <= `SSD_OFFS_RST;
         limlo_reg <= `SSD_LIMLO_RST;
         limhi_reg <= `SSD_LIMHI_RST;
      end else if (wr_fin) begin
         case (PADDR_I)
            `SSD_A_CTRL: ctrl_reg <= PWDATA_I[6:0];
            `SSD_A_STCNT: stcnt_reg <= PWDATA_I[SW-1:0];
            `SSD_A_SCALE: scale_reg <= PWDATA_I[SW-1:0];
            `SSD_A_OFFS: offs_reg <= PWDATA_I;
            `SSD_A_LIMLO: limlo_reg <= PWDATA_I;
            `SSD_A_LIMHI: limhi_reg <= PWDATA_I;
            `SSD_A_ORISE: orise_reg <= PWDATA_I[15:0];
            `SSD_A_OFALL: ofall_reg <= PWDATA_I[15:0];
            `SSD_A_OEN: oen_reg <= PWDATA_I[15:0];
            `SSD_A_SEN: sen_reg <= PWDATA_I[7:0];
            `SSD_A_SRE: sre_reg <= PWDATA_I[7:0];
            `SSD_A_IEN: ien_reg <= PWDATA_I[3:0];
            default: ien_reg <= ien_reg;
         endcase
      end
   end

   // command sequencing
   always @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         wai_reg <= 1'b0;
         slot_vld_reg <= 1'b0;
         slot_op_reg <= 4'h0;
         opc_arm_reg <= 1'b0;
         opcq_arm_reg <= 1'b0;
         obuf_vld_reg <= 1'b0;
      end else begin
         // hold commands accepted during a wait
         if (cmd_wr & (wai_reg | slot_vld_reg)) begin
            slot_vld_reg <= 1'b1;
            slot_op_reg <= PWDATA_I[3:0];
         end else if (slot_go) begin
            slot_vld_reg <= 1'b0;
         end
         if (ex & (ex_op == `SSD_CMD_WAIT)) begin
            wai_reg <= 1'b1;
         end else if (~busy) begin
            wai_reg <= 1'b0;
         end
         if (ex & (ex_op == `SSD_CMD_OPC)) begin
            opc_arm_reg <= 1'b1;
         end else if (opc_set | ex_cls) begin
            opc_arm_reg <= 1'b0;
         end
         // query answer, set wins so an answer is never lost
         if (ex & (ex_op == `SSD_CMD_OPCQ)) begin
            opcq_arm_reg <= 1'b1;
         end else if (opcq_arm_reg & ~busy) begin
            opcq_arm_reg <= 1'b0;
         end
         obuf_vld_reg <= (opcq_arm_reg & ~busy) |
                         (obuf_vld_reg & ~ex_cls & ~(rd_fin & (PADDR_I == `SSD_A_OBUF)));
      end
   end

   // measurement run and statistics
   always @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         run_reg <= 1'b0;
         mwait_reg <= 1'b0;
         MEAS_START_O <= 1'b0;
         remain_reg <= {SW{1'b0}};
         n_reg <= {SW{1'b0}};
         sum_reg <= {SUMW{1'b0}};
         div_go_reg <= 1'b0;
         raw_reg <= {DW{1'b0}};
         mean_reg <= {DW{1'b0}};
      end else begin
         MEAS_START_O <= 1'b0;
         div_go_reg <= 1'b0;
         if (ex_init) begin
            run_reg <= 1'b1;
            mwait_reg <= 1'b0;
            sum_reg <= {SUMW{1'b0}};
            n_reg <= {SW{1'b0}};
            if (ctrl_reg[`SSD_CTL_AUTO] & s_en & (stcnt_reg != {SW{1'b0}})) begin
               remain_reg <= stcnt_reg;
            end else begin
               remain_reg <= {{(SW-1){1'b0}}, 1'b1};
            end
         end else if (ex_rst) begin
            run_reg <= 1'b0;
            mwait_reg <= 1'b0;
         end else begin
            if (run_reg & ~mwait_reg) begin
               MEAS_START_O <= 1'b1;
               mwait_reg <= 1'b1;
            end
            if (take) begin
               mwait_reg <= 1'b0;
               raw_reg <= MEAS_DATA_I;
               sum_reg <= sum_reg + {{(SUMW-DW){1'b0}}, mval};
               n_reg <= n_reg + {{(SW-1){1'b0}}, 1'b1};
               remain_reg <= remain_reg - {{(SW-1){1'b0}}, 1'b1};
               if (last) begin
                  run_reg <= 1'b0;
                  div_go_reg <= s_en;
               end
            end
         end
         if (div_done) begin
            mean_reg <= div_quo[DW-1:0];
         end
      end
   end

   // display refresh and blanking
   always @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         dval_reg <= {DW{1'b0}};
         dlim_reg <= 2'h0;
         DISP_VALUE_O <= {DW{1'b0}};
         DISP_MODE_O <= `SSD_MODE_RAW;
         DISP_LIMIT_O <= 2'h0;
         DISP_BLANK_O <= 1'b0;
      end else begin
         if (stats_sel & div_done) begin
            dval_reg <= div_quo[DW-1:0];
         end else if (stats_sel & ex_recalc) begin
            dval_reg <= mean_reg;
         end else if (refresh & ~stats_sel) begin
            dval_reg <= mval;
            dlim_reg <= {above, below};
         end
         DISP_BLANK_O <= ~d_en;
         DISP_VALUE_O <= d_en ? dval_reg : {DW{1'b0}};
         DISP_LIMIT_O <= (d_en & graph) ? dlim_reg : 2'h0;
         // four modes, blanking is on DISP_BLANK_O, not a mode
         DISP_MODE_O <= stats_sel ? `SSD_MODE_STATS :
                        graph ? `SSD_MODE_GRAPH :
                        m_en ? `SSD_MODE_SCALED : `SSD_MODE_RAW;
      end
   end
endmodule // ssd_top
`default_nettype wire

// file: verif/ssd_top_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "ssd_defs.vh"
module ssd_top_chk #(
   parameter DW = 32
) (
   // clock, reset, bus handshake
   input wire logic CLK_I,
   input wire logic RST_N_I,
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PREADY_O,
   input wire logic PSLVERR_O,
   // front end
   input wire logic MEAS_VALID_I,
   input wire logic MEAS_START_O,
   // display and service request
   input wire logic [DW-1:0] DISP_VALUE_O,
   input wire logic [2:0] DISP_MODE_O,
   input wire logic [1:0] DISP_LIMIT_O,
   input wire logic DISP_BLANK_O,
   input wire logic REMOTE_LED_O,
   input wire logic SRQ_LED_O,
   input wire logic SRQ_O,
   input wire logic IRQ_O
);
   logic pend_reg;
   logic pend_next;
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!RST_N_I);
   // a start is open until its result comes back
   assign pend_next = MEAS_START_O | (pend_reg & ~MEAS_VALID_I);
   always @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         pend_reg <= 1'b0;
      end else begin
         pend_reg <= pend_next;
      end
   end
   property p_mode_boot;
      $rose(RST_N_I) |-> DISP_MODE_O == `SSD_MODE_RAW;
   endproperty
   a_mode_boot: assert property (p_mode_boot) else $error("mode not raw after reset");
   property p_blank_dark;
      DISP_BLANK_O |-> DISP_VALUE_O == '0 && DISP_LIMIT_O == 2'h0;
   endproperty
   a_blank_dark: assert property (p_blank_dark) else $error("blanked display not dark");
   property p_srq_lamp;
      SRQ_LED_O == SRQ_O;
   endproperty
   a_srq_lamp: assert property (p_srq_lamp) else $error("service lamp differs");
   property p_remote_lamp;
      $rose(REMOTE_LED_O) |-> $past(PREADY_O) ##1 REMOTE_LED_O [*4];
   endproperty
   a_remote_lamp: assert property (p_remote_lamp) else $error("remote lamp wrong");
   property p_limit_graph;
      DISP_LIMIT_O != 2'h0 |-> DISP_MODE_O == `SSD_MODE_GRAPH && !DISP_BLANK_O;
   endproperty
   a_limit_graph: assert property (p_limit_graph) else $error("limit outside graph mode");
   property p_start_pulse;
      MEAS_START_O |=> !MEAS_START_O;
   endproperty
   a_start_pulse: assert property (p_start_pulse) else $error("start longer than a cycle");
   property p_one_pending;
      MEAS_START_O |-> !pend_reg;
   endproperty
   a_one_pending: assert property (p_one_pending) else $error("start while one is open");
   property p_ready_held;
      PREADY_O |-> PSEL_I && PENABLE_I && $past(PSEL_I && PENABLE_I);
   endproperty
   a_ready_held: assert property (p_ready_held) else $error("ready without access");
   c_srq: cover property ($rose(SRQ_O));
   c_irq: cover property ($rose(IRQ_O));
   c_blank: cover property ($rose(DISP_BLANK_O));
   c_err: cover property (PSLVERR_O);
endmodule // ssd_top_chk
bind ssd_top ssd_top_chk #(.DW(DW)) u_ssd_top_chk (.CLK_I(CLK_I), .RST_N_I(RST_N_I),
   .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
   .MEAS_VALID_I(MEAS_VALID_I), .MEAS_START_O(MEAS_START_O), .DISP_VALUE_O(DISP_VALUE_O),
   .DISP_MODE_O(DISP_MODE_O), .DISP_LIMIT_O(DISP_LIMIT_O), .DISP_BLANK_O(DISP_BLANK_O),
   .REMOTE_LED_O(REMOTE_LED_O), .SRQ_LED_O(SRQ_LED_O), .SRQ_O(SRQ_O), .IRQ_O(IRQ_O));
`default_nettype wire

// file: verif/ssd_fe_model.sv
`timescale 1ns/1ps
`default_nettype none
module ssd_fe_model (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // request and answer
   input wire logic start_i,
   input wire logic [7:0] delay_i,
   input wire logic [31:0] value_i,
   output logic valid_o,
   output logic [31:0] data_o
);
   logic busy;
   logic [7:0] cnt;
   initial begin
      valid_o = 1'b0;
      data_o = 32'h0;
   end
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         busy <= 1'b0;
         cnt <= 8'h0;
         valid_o <= 1'b0;
         data_o <= 32'h0;
      end else begin
         valid_o <= 1'b0;
         // data toggles off the strobe so a stale value cannot pass
         data_o <= ~data_o;
         if (start_i && !busy) begin
            busy <= 1'b1;
            cnt <= delay_i;
         end else if (busy && cnt == 8'h0) begin
            busy <= 1'b0;
            valid_o <= 1'b1;
            data_o <= value_i;
         end else if (busy) begin
            cnt <= cnt - 8'h1;
         end
      end
   end
endmodule // ssd_fe_model
`default_nettype wire

// file: verif/ssd_top_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "ssd_defs.vh"
module ssd_top_test;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, meas_data, disp_value, rd;
   logic pready, pslverr, meas_valid, meas_start, err;
   logic [2:0] disp_mode;
   logic [1:0] disp_limit;
   logic disp_blank, remote_led, srq_led, srq, irq;
   logic [7:0] fe_delay = 8'd40;
   int num_errors = 0;
   int checked = 0;
   int starts = 0;
   int s0;
   always #2.5 clk_i = ~clk_i;
   always @(posedge clk_i) if (meas_start === 1'b1) starts <= starts + 1;
   ssd_top u_ssd_top (.CLK_I(clk_i), .RST_N_I(rst_n_i), .PSEL_I(psel), .PENABLE_I(penable),
      .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
      .PREADY_O(pready), .PSLVERR_O(pslverr), .MEAS_VALID_I(meas_valid),
      .MEAS_DATA_I(meas_data), .MEAS_START_O(meas_start), .DISP_VALUE_O(disp_value),
      .DISP_MODE_O(disp_mode), .DISP_LIMIT_O(disp_limit), .DISP_BLANK_O(disp_blank),
      .REMOTE_LED_O(remote_led), .SRQ_LED_O(srq_led), .SRQ_O(srq), .IRQ_O(irq));
   ssd_fe_model u_ssd_fe_model (.clk_i(clk_i), .rst_n_i(rst_n_i), .start_i(meas_start),
      .delay_i(fe_delay), .value_i(32'd1000), .valid_o(meas_valid), .data_o(meas_data));
   task automatic fail(input string m);
      num_errors++;
      $display("unexpected at %0t: %s", $time, m);
   endtask
   task automatic test_done;
      $display("checked %0d num_errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // one transfer; the request is held until ready is sampled
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_i);
      penable <= 1'b1;
      do begin
         @(posedge clk_i);
         n++;
      end while (pready !== 1'b1 && n < 4000);
      if (n >= 4000) fail("no ready");
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask
   task automatic cmd(input logic [3:0] c);
      xfer(1'b1, `SSD_A_CMD, {28'h0, c});
   endtask
   task automatic chk_rd(input logic [7:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0);
      checked++;
      if (rd !== exp) fail($sformatf("reg %h got %h want %h", a, rd, exp));
   endtask
   task automatic chk_pin(input logic [31:0] got, input logic [31:0] exp, input string s);
      checked++;
      if (got !== exp) fail($sformatf("%s got %h want %h", s, got, exp));
   endtask
   task automatic wait_srq;
      int n;
      n = 0;
      while (srq !== 1'b1 && n < 4000) begin
         @(posedge clk_i);
         n++;
      end
      if (n >= 4000) fail("no service request");
   endtask
   initial begin
      #100000;
      fail("watchdog");
      test_done;
   end
   initial begin
      repeat (16) @(posedge clk_i);
      rst_n_i <= 1'b1;
      chk_rd(`SSD_A_CTRL, 32'h8);
      chk_rd(`SSD_A_SCALE, 32'h1);
      chk_rd(`SSD_A_OFFS, 32'h0);
      chk_rd(`SSD_A_STCNT, 32'h64);
      chk_rd(`SSD_A_LIMHI, 32'hffffffff);
      chk_pin({29'h0, disp_mode}, 32'h0, "mode");
      chk_rd(8'h54, 32'h0);
      chk_pin({31'h0, err}, 32'h1, "slverr");
      $display("test reset done");
      cmd(`SSD_CMD_RST);
      cmd(`SSD_CMD_CLS);
      wr(`SSD_A_SRE, 32'h0);
      wr(`SSD_A_SEN, 32'h0);
      wr(`SSD_A_ORISE, 32'h0);
      wr(`SSD_A_OFALL, 32'h10);
      wr(`SSD_A_OEN, 32'h10);
      wr(`SSD_A_SRE, 32'h80);
      wr(`SSD_A_IEN, 32'h1);
      cmd(`SSD_CMD_INIT);
      chk_rd(`SSD_A_OCOND, 32'h10);
      chk_rd(`SSD_A_OEVT, 32'h0);
      wait_srq;
      chk_rd(`SSD_A_STB, 32'hc0);
      chk_rd(`SSD_A_OCOND, 32'h0);
      chk_pin({31'h0, irq}, 32'h1, "irq");
      wr(`SSD_A_IEN, 32'h0);
      chk_rd(`SSD_A_ISTAT, 32'h5);
      chk_pin({31'h0, irq}, 32'h0, "irq masked");
      wr(`SSD_A_ICLR, 32'h5);
      chk_rd(`SSD_A_ISTAT, 32'h0);
      chk_rd(`SSD_A_OEVT, 32'h10);
      chk_rd(`SSD_A_OEVT, 32'h0);
      chk_rd(`SSD_A_STB, 32'h0);
      chk_pin({31'h0, srq}, 32'h0, "srq");
      $display("test status done");
      fe_delay <= 8'd20;
      wr(`SSD_A_SRE, 32'h20);
      wr(`SSD_A_SEN, 32'h1);
      wr(`SSD_A_STCNT, 32'd50);
      wr(`SSD_A_CTRL, 32'h5c);
      s0 = starts;
      cmd(`SSD_CMD_INIT);
      cmd(`SSD_CMD_OPC);
      wait_srq;
      chk_rd(`SSD_A_STB, 32'he0);
      chk_rd(`SSD_A_SEVT, 32'h1);
      chk_pin(starts - s0, 32'd50, "starts");
      chk_pin({29'h0, disp_mode}, 32'h3, "mode");
      chk_rd(`SSD_A_DVAL, 32'd1000);
      wr(`SSD_A_SRE, 32'h0);
      s0 = starts;
      cmd(`SSD_CMD_INIT);
      cmd(`SSD_CMD_WAIT);
      cmd(`SSD_CMD_RECALC);
      chk_rd(`SSD_A_OCOND, 32'h10);
      cmd(`SSD_CMD_OPCQ);
      chk_rd(`SSD_A_OCOND, 32'h0);
      chk_rd(`SSD_A_OBUF, 32'h1);
      chk_pin(starts - s0, 32'd50, "starts");
      $display("test sync done");
      cmd(`SSD_CMD_RST);
      fe_delay <= 8'd3;
      wr(`SSD_A_CTRL, 32'h9);
      cmd(`SSD_CMD_INIT);
      cmd(`SSD_CMD_OPCQ);
      chk_rd(`SSD_A_OBUF, 32'h1);
      chk_rd(`SSD_A_OCOND, 32'h0);
      chk_rd(`SSD_A_DVAL, 32'd1000);
      chk_pin({29'h0, disp_mode}, 32'h1, "mode");
      wr(`SSD_A_SCALE, 32'h3);
      wr(`SSD_A_OFFS, 32'h5);
      cmd(`SSD_CMD_RECALC);
      chk_rd(`SSD_A_DVAL, 32'd3005);
      wr(`SSD_A_LIMHI, 32'd3000);
      wr(`SSD_A_CTRL, 32'h2b);
      cmd(`SSD_CMD_RECALC);
      chk_rd(`SSD_A_DVAL, 32'd3005);
      chk_pin({29'h0, disp_mode}, 32'h2, "mode");
      chk_pin({30'h0, disp_limit}, 32'h2, "limit");
      wr(`SSD_A_CTRL, 32'h23);
      chk_rd(`SSD_A_CTRL, 32'h23);
      chk_pin({31'h0, disp_blank}, 32'h1, "blank");
      chk_pin(disp_value, 32'h0, "value");
      chk_pin({31'h0, remote_led}, 32'h1, "remote");
      wr(`SSD_A_CTRL, 32'h2b);
      chk_rd(`SSD_A_CTRL, 32'h2b);
      chk_pin(disp_value, 32'd3005, "value");
      $display("test display done");
      test_done;
   end
endmodule // ssd_top_test
`default_nettype wire
